// ### hw/radio_spi_device.sv
`timescale 1ns/1ps
// Contract
// - Device is slave; host drives select, clock, data
// - Single byte and unlimited bursts, read and write
// - Serial clock asynchronous; port synchronises both ways
// - Port works in every mode but reset
// - Control byte shifts out primary interrupt status
// - Host clock at most 16 MHz write, 9 MHz read
// - Burst address increments after each data byte
// - Data output released while port inactive
// - Select low frames a transaction; high ends it
// - Transactions are whole eight-bit transfers
// - Clock idles low; sample rising, change falling
// - Bytes travel most significant bit first
// - One control byte first, then data
// - Indirect and buffer byte mode add address byte
// - Control bit 7: one read, zero write
// - Control bit 6: one buffer, zero registers
// - Register access uses six low control bits
// - Buffer: bit 5 byte mode; low five ignored
// - Packet buffer holds 128 shared bytes
module radio_spi_device
   import radio_spi_pkg::*;
#(
   parameter int IND_DEPTH = IND_DEPTH_DEF
)
(
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   radio_spi_if.device LINK,
   input wire logic [7:0] I_IRQ_SET,
   output logic O_ACTIVE,
   output logic O_REG_WE,
   output logic [5:0] O_REG_ADDR,
   output logic [7:0] O_REG_WDATA,
   output logic [7:0] O_IRQ_STATUS
);

   localparam int IND_AW = $clog2(IND_DEPTH);

   logic ssel_n_s;
   logic sclk_s;
   logic mosi_s;
   logic sclk_prev_q;
   logic sel;
   logic rise;
   logic fall;
   logic byte_done;
   logic [7:0] byte_in;
   logic [2:0] bit_cnt_q;
   logic [7:0] shin_q;
   logic [7:0] tx_q;
   logic [7:0] tx_d;
   logic miso_q;
   logic oe_q;
   dev_state_type state_q;
   dev_state_type state_d;
   space_type space_q;
   space_type space_d;
   logic [7:0] addr_q;
   logic [7:0] addr_d;
   logic read_q;
   logic read_d;
   logic byte_mode_q;
   logic byte_mode_d;
   logic wr_en;
   logic [7:0] rd_byte;
   logic [7:0] irq_q;
   logic [7:0] irq_clr;
   logic [7:0] dir_q [DIRECT_DEPTH];
   logic [7:0] ind_q [IND_DEPTH];
   logic [7:0] buf_q [BUF_DEPTH];

   // Pins cross into the core clock; the serial clock is only ever sampled
   spi_sync2 #(
      .W(3),
      .RESET_VAL(3'b100)
   ) spi_sync2_inst (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_async({LINK.ssel_n, LINK.serial_clk_pin, LINK.mosi}),
      .o_sync({ssel_n_s, sclk_s, mosi_s})
   );

   // Edge finder on the synchronised serial clock
   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         sclk_prev_q <= 1'b0;
      end
      else
      begin
         sclk_prev_q <= sclk_s;
      end
   end

   // Host is the only clock source; edges only count while framed
   assign sel = !ssel_n_s;
   assign rise = sel && sclk_s && !sclk_prev_q; // Sample edge
   assign fall = sel && !sclk_s && sclk_prev_q; // Change edge
   assign byte_in = {shin_q[6:0], mosi_s}; // First bit lands on top
   assign byte_done = rise && (bit_cnt_q == 3'd7); // Eight bits per unit

   // Decode of each completed byte
   always_comb
   begin
      state_d = state_q;
      space_d = space_q;
      addr_d = addr_q;
      read_d = read_q;
      byte_mode_d = byte_mode_q;
      wr_en = 1'b0;
      case (state_q)
         ST_CTRL:
         begin
            read_d = byte_in[CTRL_DIR_BIT]; // One reads, zero writes
            byte_mode_d = byte_in[CTRL_MODE_BIT];
            if (byte_in[CTRL_TGT_BIT]) // Buffer or register target
            begin
               // Low five bits are don't-care for the buffer
               space_d = SP_BUFFER;
               addr_d = 8'h00;
               state_d = byte_in[CTRL_MODE_BIT] ? ST_ADDR : ST_DATA;
            end
            else
            begin
               addr_d = {2'b00, byte_in[REG_AW-1:0]};
               if (byte_in[REG_AW-1:0] == INDIRECT_ADDR)
               begin
                  space_d = SP_INDIRECT;
                  state_d = ST_ADDR;
               end
               else
               begin
                  space_d = SP_DIRECT;
                  state_d = ST_DATA;
               end
            end
         end
         ST_ADDR:
         begin
            addr_d = byte_in; // Extra address byte before data
            state_d = ST_DATA;
         end
         ST_DATA:
         begin
            wr_en = !read_q; // Any count of data bytes
            addr_d = addr_q + 8'h01; // Step after each byte
            if (space_q == SP_BUFFER && byte_mode_q)
            begin
               state_d = ST_IGNORE; // Byte mode moves one byte only
            end
         end
         default:
         begin
            state_d = ST_IGNORE;
         end
      endcase
   end

   // Read path for the byte that goes out next; each space wraps at its size
   always_comb
   begin
      case (space_d)
         SP_BUFFER: rd_byte = buf_q[addr_d[BUF_AW-1:0]];
         SP_INDIRECT: rd_byte = ind_q[addr_d[IND_AW-1:0]];
         default:
         begin
            if (addr_d[REG_AW-1:0] == IRQ_STATUS_ADDR)
            begin
               rd_byte = irq_q;
            end
            else
            begin
               rd_byte = dir_q[addr_d[REG_AW-1:0]];
            end
         end
      endcase
      tx_d = (state_d == ST_DATA && read_d) ? rd_byte : 8'h00;
   end

   // Transaction state; a high select throws away any part byte
   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N || !sel)
      begin
         state_q <= ST_CTRL;
         space_q <= SP_DIRECT;
         addr_q <= 8'h00;
         read_q <= 1'b0;
         byte_mode_q <= 1'b0;
      end
      else if (byte_done)
      begin
         state_q <= state_d;
         space_q <= space_d;
         addr_q <= addr_d;
         read_q <= read_d;
         byte_mode_q <= byte_mode_d;
      end
   end

   // Shifters; while idle the status byte waits in the transmit register
   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N || !sel)
      begin
         bit_cnt_q <= 3'd0; // Part byte is dropped here
         shin_q <= 8'h00;
         tx_q <= irq_q;
         miso_q <= irq_q[7]; // First bit ready before the first rising edge
      end
      else
      begin
         if (rise)
         begin
            shin_q <= byte_in;
            bit_cnt_q <= bit_cnt_q + 3'd1;
         end
         if (byte_done)
         begin
            tx_q <= tx_d;
         end
         if (fall)
         begin
            miso_q <= tx_q[3'd7 - bit_cnt_q]; // Changes on the falling edge
         end
      end
   end

   // Output is driven only while selected, so other slaves may share it
   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         oe_q <= 1'b0;
      end
      else
      begin
         oe_q <= sel;
      end
   end

   assign LINK.miso_o = miso_q;
   assign LINK.miso_oe = oe_q;

   // Storage; a write commits only on the eighth bit
   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         for (int i = 0; i < DIRECT_DEPTH; i++)
         begin
            dir_q[i] <= STORE_RST;
         end
         for (int i = 0; i < IND_DEPTH; i++)
         begin
            ind_q[i] <= STORE_RST;
         end
         for (int i = 0; i < BUF_DEPTH; i++)
         begin
            buf_q[i] <= STORE_RST;
         end
      end
      else if (byte_done && wr_en)
      begin
         case (space_q)
            SP_BUFFER: buf_q[addr_q[BUF_AW-1:0]] <= byte_in;
            SP_INDIRECT: ind_q[addr_q[IND_AW-1:0]] <= byte_in;
            default: dir_q[addr_q[REG_AW-1:0]] <= byte_in;
         endcase
      end
   end

   // Status clears by writing ones; a new event in the same cycle wins
   assign irq_clr = (byte_done && wr_en && space_q == SP_DIRECT
      && addr_q[REG_AW-1:0] == IRQ_STATUS_ADDR) ? byte_in : 8'h00;

   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         irq_q <= IRQ_STATUS_RST;
      end
      else
      begin
         irq_q <= (irq_q & ~irq_clr) | I_IRQ_SET;
      end
   end

   // Core side notice of direct writes; no power-mode gating anywhere
   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         O_REG_WE <= 1'b0;
         O_REG_ADDR <= 6'h00;
         O_REG_WDATA <= 8'h00;
         O_ACTIVE <= 1'b0;
      end
      else
      begin
         O_REG_WE <= byte_done && wr_en && space_q == SP_DIRECT;
         O_ACTIVE <= sel;
         if (byte_done && wr_en && space_q == SP_DIRECT)
         begin
            O_REG_ADDR <= addr_q[REG_AW-1:0];
            O_REG_WDATA <= byte_in;
         end
      end
   end

   assign O_IRQ_STATUS = irq_q;

endmodule : radio_spi_device

// ### hw/radio_spi_host.sv
`timescale 1ns/1ps
module radio_spi_host
   import radio_spi_pkg::*;
#(
   parameter int HALF_WR = HALF_WR_CYC,
   parameter int HALF_RD = HALF_RD_CYC,
   parameter int LEAD = LEAD_CYC
)
(
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   radio_spi_if.host LINK,
   input wire logic I_TX_VALID,
   input wire logic [7:0] I_TX_BYTE,
   input wire logic I_TX_LAST,
   output logic O_TX_READY,
   output logic O_RX_VALID,
   output logic [7:0] O_RX_BYTE,
   output logic O_BUSY
);

   host_state_type state_q;
   logic [7:0] cnt_q;
   logic [7:0] half_q;
   logic [2:0] bit_cnt_q;
   logic [7:0] sh_q;
   logic [7:0] rx_q;
   logic last_q;
   logic ssel_n_q;
   logic sclk_q;
   logic miso_s;

   // The returned line comes from another timing domain
   spi_sync2 #(
      .W(1),
      .RESET_VAL(1'b1)
   ) spi_sync2_inst (
      .i_clk(I_CLK),
      .i_reset_n(I_RESET_N),
      .i_async(LINK.miso),
      .o_sync(miso_s)
   );

   // New bytes are taken only between bytes, with the clock parked low
   assign O_TX_READY = (state_q == H_IDLE) || (state_q == H_GAP);
   assign O_BUSY = (state_q != H_IDLE);

   // Host makes the frame and clock by dividing its own clock
   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N)
      begin
         state_q <= H_IDLE;
         cnt_q <= 8'h00;
         half_q <= 8'h00;
         bit_cnt_q <= 3'd0;
         sh_q <= 8'h00;
         rx_q <= 8'h00;
         last_q <= 1'b0;
         ssel_n_q <= 1'b1;
         sclk_q <= 1'b0;
         O_RX_VALID <= 1'b0;
         O_RX_BYTE <= 8'h00;
      end
      else
      begin
         O_RX_VALID <= 1'b0;
         case (state_q)
            H_IDLE:
            begin
               if (I_TX_VALID)
               begin
                  // Reads need the slower clock
                  half_q <= I_TX_BYTE[CTRL_DIR_BIT] ? 8'(HALF_RD) : 8'(HALF_WR);
                  sh_q <= I_TX_BYTE;
                  last_q <= I_TX_LAST;
                  ssel_n_q <= 1'b0;
                  cnt_q <= 8'(LEAD);
                  state_q <= H_LEAD;
               end
            end
            H_LEAD, H_LOW:
            begin
               if (cnt_q <= 8'h01)
               begin
                  sclk_q <= 1'b1; // Rising edge: the device samples; the host samples at the end of the high phase
                  cnt_q <= half_q;
                  state_q <= H_HIGH;
               end
               else
               begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            H_HIGH:
            begin
               if (cnt_q <= 8'h01)
               begin
                  // Last moment of the high phase, line still valid
                  sclk_q <= 1'b0;
                  rx_q <= {rx_q[6:0], miso_s};
                  bit_cnt_q <= bit_cnt_q + 3'd1;
                  cnt_q <= half_q;
                  if (bit_cnt_q == 3'd7) // Whole bytes only
                  begin
                     O_RX_VALID <= 1'b1;
                     O_RX_BYTE <= {rx_q[6:0], miso_s};
                     state_q <= last_q ? H_TRAIL : H_GAP;
                  end
                  else
                  begin
                     sh_q <= {sh_q[6:0], 1'b0}; // Data changes on falling edge
                     state_q <= H_LOW;
                  end
               end
               else
               begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            H_GAP:
            begin
               if (I_TX_VALID)
               begin
                  sh_q <= I_TX_BYTE;
                  last_q <= I_TX_LAST;
                  cnt_q <= half_q;
                  state_q <= H_LOW;
               end
            end
            H_TRAIL:
            begin
               if (cnt_q <= 8'h01)
               begin
                  ssel_n_q <= 1'b1; // Ends the transaction
                  cnt_q <= 8'(LEAD);
                  state_q <= H_PAUSE;
               end
               else
               begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            H_PAUSE:
            begin
               if (cnt_q <= 8'h01)
               begin
                  state_q <= H_IDLE;
               end
               else
               begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default:
            begin
               state_q <= H_IDLE;
            end
         endcase
      end
   end

   assign LINK.ssel_n = ssel_n_q;
   assign LINK.serial_clk_pin = sclk_q; // Idles low
   assign LINK.mosi = sh_q[7]; // Most significant bit first

endmodule : radio_spi_host

// ### hw/spi_sync2.sv
`timescale 1ns/1ps
module spi_sync2
#(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
)
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   logic [W-1:0] meta_q;

   // Two stages; only the second stage is visible outside
   always_ff @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         meta_q <= RESET_VAL;
         o_sync <= RESET_VAL;
      end
      else
      begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule : spi_sync2

// ### inc/radio_spi_if.sv
`timescale 1ns/1ps
interface radio_spi_if;
   logic ssel_n;
   logic serial_clk_pin;
   logic mosi;
   logic miso_o;
   logic miso_oe;
   logic miso;

   // Shared line with a pull-up: released means high
   assign miso = miso_oe ? miso_o : 1'b1;

   modport device (
      input ssel_n,
      input serial_clk_pin,
      input mosi,
      output miso_o,
      output miso_oe
   );

   modport host (
      output ssel_n,
      output serial_clk_pin,
      output mosi,
      input miso
   );
endinterface : radio_spi_if

// ### inc/radio_spi_pkg.sv
package radio_spi_pkg;

   // Core clock and the serial clock ceilings
   localparam int CLK_MHZ = 125;
   localparam int SCLK_WR_MAX_MHZ = 16;
   localparam int SCLK_RD_MAX_MHZ = 9;
   // Half periods round up so the host never exceeds the ceiling
   localparam int HALF_WR_CYC = (CLK_MHZ + 2 * SCLK_WR_MAX_MHZ - 1) / (2 * SCLK_WR_MAX_MHZ);
   localparam int HALF_RD_CYC = (CLK_MHZ + 2 * SCLK_RD_MAX_MHZ - 1) / (2 * SCLK_RD_MAX_MHZ);
   // Select setup before the clock burst and deselected pause after the frame, in core cycles
   localparam int LEAD_CYC = 8;

   // Control byte layout
   localparam int CTRL_DIR_BIT = 7;
   localparam int CTRL_TGT_BIT = 6;
   localparam int CTRL_MODE_BIT = 5;
   localparam int REG_AW = 6;

   // Address spaces
   localparam int DIRECT_DEPTH = 64;
   localparam int BUF_DEPTH = 128;
   localparam int BUF_AW = 7;
   localparam int IND_DEPTH_DEF = 64;
   localparam logic [5:0] IRQ_STATUS_ADDR = 6'h00;
   localparam logic [5:0] INDIRECT_ADDR = 6'h3f;

   // Reset values
   localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
   localparam logic [7:0] STORE_RST = 8'h00;

   typedef enum logic [1:0] {ST_CTRL, ST_ADDR, ST_DATA, ST_IGNORE} dev_state_type;
   typedef enum logic [1:0] {SP_DIRECT, SP_INDIRECT, SP_BUFFER} space_type;
   typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_GAP, H_TRAIL, H_PAUSE}
      host_state_type;

endpackage : radio_spi_pkg

// ### tb/radio_spi_link_checker.sv
`timescale 1ns/1ps
module radio_spi_link_checker
(
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic ssel_n,
   input wire logic serial_clk_pin,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic miso
);
   logic [11:0] rise_cnt_q;
   logic sclk_prev_q;
   logic rd_frame_q;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);

   // Rising clock edges per frame; cleared while deselected so each frame starts at zero
   always_ff @(posedge I_CLK)
   begin
      sclk_prev_q <= serial_clk_pin;
      if (!I_RESET_N || ssel_n)
         rise_cnt_q <= 12'h000;
      else if (serial_clk_pin && !sclk_prev_q)
         rise_cnt_q <= rise_cnt_q + 12'h001;
   end

   // First bit of the control byte marks a read frame, which needs the slower clock
   always_ff @(posedge I_CLK)
   begin
      if (!I_RESET_N || ssel_n)
         rd_frame_q <= 1'b0;
      else if (serial_clk_pin && !sclk_prev_q && rise_cnt_q == 12'h000)
         rd_frame_q <= mosi;
   end

   sequence s_lead;
      !serial_clk_pin [*7];
   endsequence
   sequence s_high_wr;
      serial_clk_pin [*4];
   endsequence
   sequence s_high_rd;
      serial_clk_pin [*7];
   endsequence
   sequence s_low_rd;
      !serial_clk_pin [*7];
   endsequence

   a_clk_idle_low: assert property (ssel_n |-> !serial_clk_pin)
      else $error("serial clock high while deselected");
   a_oe_on_select: assert property ($fell(ssel_n) |-> ##[2:4] miso_oe)
      else $error("data output not enabled after select");
   a_oe_on_release: assert property ($rose(ssel_n) |-> ##[2:4] !miso_oe)
      else $error("data output not released after deselect");
   a_idle_released: assert property (ssel_n [*6] |-> !miso_oe && miso)
      else $error("data line not released while idle");
   a_mosi_change_low: assert property ($changed(mosi) |-> !serial_clk_pin)
      else $error("host data changed while clock high");
   a_high_phase_min: assert property ($rose(serial_clk_pin) |-> s_high_wr)
      else $error("clock high phase too short");
   a_low_phase_min: assert property ($fell(serial_clk_pin) |-> !serial_clk_pin [*4])
      else $error("clock low phase too short");
   a_read_rate: assert property ($rose(serial_clk_pin) && rd_frame_q |-> s_high_rd)
      else $error("read frame clock too fast");
   a_read_low: assert property ($fell(serial_clk_pin) && rd_frame_q |-> s_low_rd)
      else $error("read frame clock low phase too short");
   a_select_lead: assert property ($fell(ssel_n) |-> s_lead)
      else $error("clock started too soon after select");
   a_whole_bytes: assert property ($rose(ssel_n) |->
      rise_cnt_q[2:0] == 3'h0 && rise_cnt_q != 12'h000)
      else $error("frame not a whole number of bytes");
endmodule : radio_spi_link_checker

// ### tb/radio_spi_slave_port_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; $display("MISMATCH t=%0t got %h want %h", $time, a, e); end end
module radio_spi_slave_port_bench;
   import radio_spi_pkg::*;
   typedef logic [7:0] bytes_type[$];
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tx_valid = 1'b0;
   logic [7:0] tx_byte = 8'h00;
   logic tx_last = 1'b0;
   logic [7:0] irq_set = 8'h00;
   logic tx_ready, rx_valid, busy, active, reg_we, we_b;
   logic [7:0] rx_byte, reg_wdata, irq_status;
   logic [5:0] reg_addr;
   int err_total = 0;
   int cmp_count = 0;
   int we_b_cnt = 0;
   bytes_type rx_q;
   bytes_type q;
   logic [13:0] wr_q[$];

   radio_spi_if link_if();
   radio_spi_if bang_if();

   radio_spi_host radio_spi_host_inst (.I_CLK(clk), .I_RESET_N(rst_n), .LINK(link_if.host),
      .I_TX_VALID(tx_valid), .I_TX_BYTE(tx_byte), .I_TX_LAST(tx_last), .O_TX_READY(tx_ready),
      .O_RX_VALID(rx_valid), .O_RX_BYTE(rx_byte), .O_BUSY(busy));
   radio_spi_device radio_spi_device_inst (.I_CLK(clk), .I_RESET_N(rst_n),
      .LINK(link_if.device), .I_IRQ_SET(irq_set), .O_ACTIVE(active), .O_REG_WE(reg_we),
      .O_REG_ADDR(reg_addr), .O_REG_WDATA(reg_wdata), .O_IRQ_STATUS(irq_status));
   // Second device faces the bench directly so a broken frame can be offered
   radio_spi_device radio_spi_device_inst_b (.I_CLK(clk), .I_RESET_N(rst_n),
      .LINK(bang_if.device), .I_IRQ_SET(8'h00), .O_ACTIVE(), .O_REG_WE(we_b),
      .O_REG_ADDR(), .O_REG_WDATA(), .O_IRQ_STATUS());
   radio_spi_link_checker radio_spi_link_checker_inst (.I_CLK(clk), .I_RESET_N(rst_n),
      .ssel_n(link_if.ssel_n), .serial_clk_pin(link_if.serial_clk_pin), .mosi(link_if.mosi),
      .miso_o(link_if.miso_o), .miso_oe(link_if.miso_oe), .miso(link_if.miso));

   always #4 clk = ~clk;

   // Capture mid-cycle so flop outputs are settled
   always @(negedge clk)
   begin
      if (rx_valid === 1'b1)
         rx_q.push_back(rx_byte);
      if (reg_we === 1'b1)
         wr_q.push_back({reg_addr, reg_wdata});
      if (we_b === 1'b1)
         we_b_cnt++;
   end

   // One whole frame through the host; waits are bounded, the watchdog backs them up
   task automatic xfer(input bytes_type tx);
      int n;
      rx_q = {};
      wr_q = {};
      for (int i = 0; i < tx.size(); i++)
      begin
         n = 0;
         while (tx_ready !== 1'b1 && n < 4000)
         begin
            @(negedge clk);
            n++;
         end
         `CHK(n < 4000, 1'b1)
         tx_valid = 1'b1;
         tx_byte = tx[i];
         tx_last = (i == tx.size() - 1);
         @(negedge clk);
         tx_valid = 1'b0;
      end
      `CHK(active, 1'b1)
      n = 0;
      while (busy !== 1'b0 && n < 4000)
      begin
         @(negedge clk);
         n++;
      end
      `CHK(n < 4000, 1'b1)
      repeat (8) @(negedge clk);
      `CHK(active, 1'b0)
   endtask : xfer

   // Bench acting as host on the second link, slow enough for either direction
   task automatic bang(input logic [7:0] v, input int nbits);
      for (int i = 0; i < nbits; i++)
      begin
         bang_if.mosi = v[7 - i];
         repeat (8) @(negedge clk);
         bang_if.serial_clk_pin = 1'b1;
         repeat (8) @(negedge clk);
         bang_if.serial_clk_pin = 1'b0;
      end
   endtask : bang

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      summarize();
   end

   initial
   begin
      bang_if.ssel_n = 1'b1;
      bang_if.serial_clk_pin = 1'b0;
      bang_if.mosi = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      `CHK(link_if.miso, 1'b1)
      `CHK(irq_status, IRQ_STATUS_RST)
      irq_set = 8'h96;
      @(negedge clk);
      irq_set = 8'h00;
      xfer('{8'h05, 8'ha5});
      `CHK(rx_q[0], 8'h96)
      `CHK(wr_q[0], {6'h05, 8'ha5})
      xfer('{8'h00, 8'hff});
      `CHK(irq_status, 8'h00)
      irq_set = 8'h41;
      @(negedge clk);
      irq_set = 8'h00;
      xfer('{8'h80, 8'h00});
      `CHK(rx_q[1], 8'h41)
      `CHK(irq_status, 8'h41)
      xfer('{8'h00, 8'h41});
      `CHK(irq_status, 8'h00)
      $display("test status done");
      xfer('{8'h10, 8'h11, 8'h22, 8'h33});
      for (int i = 0; i < 3; i++)
         `CHK(wr_q[i], {6'h10 + 6'(i), 8'h11 * 8'(i + 1)})
      xfer('{8'h90, 8'h00, 8'h00, 8'h00});
      `CHK(rx_q[0], 8'h00)
      for (int i = 1; i < 4; i++)
         `CHK(rx_q[i], 8'h11 * 8'(i))
      $display("test register burst done");
      q = '{8'h5f};
      for (int i = 0; i < 129; i++)
         q.push_back(8'(i));
      xfer(q);
      xfer('{8'hc0, 8'h00, 8'h00});
      `CHK(rx_q[1], 8'h80)
      `CHK(rx_q[2], 8'h01)
      xfer('{8'h60, 8'h06, 8'h77, 8'h88});
      xfer('{8'he0, 8'h06, 8'h00});
      `CHK(rx_q[2], 8'h77)
      xfer('{8'he0, 8'h07, 8'h00});
      `CHK(rx_q[2], 8'h07)
      $display("test buffer done");
      xfer('{8'h3f, 8'h12, 8'hc3, 8'hc4});
      `CHK(wr_q.size(), 0)
      xfer('{8'hbf, 8'h12, 8'h00, 8'h00});
      `CHK(rx_q[2], 8'hc3)
      `CHK(rx_q[3], 8'hc4)
      $display("test indirect done");
      bang_if.ssel_n = 1'b0;
      repeat (8) @(negedge clk);
      bang(8'h05, 8);
      bang(8'h3c, 4);
      repeat (8) @(negedge clk);
      bang_if.ssel_n = 1'b1;
      repeat (12) @(negedge clk);
      `CHK(we_b_cnt, 0)
      `CHK(we_b, 1'b0)
      `CHK(bang_if.miso, 1'b1)
      bang_if.ssel_n = 1'b0;
      repeat (8) @(negedge clk);
      bang(8'h05, 8);
      bang(8'h3c, 8);
      repeat (8) @(negedge clk);
      bang_if.ssel_n = 1'b1;
      repeat (12) @(negedge clk);
      `CHK(we_b_cnt, 1)
      $display("test abort done");
      summarize();
   end
endmodule : radio_spi_slave_port_bench
